// *** include/mso_pkg.sv ***
// **********************************************************************
// Shared constants and types of the monitor sigma-delta output.
// **********************************************************************
package mso_pkg;
    // Clock rate and highest permitted modulator bit rate (carrier).
    localparam int CLK_HZ         = 40_000_000;
    localparam int CARRIER_MAX_HZ = 512_000;
    // A least bit period, so the cycle count rounds up.
    localparam int TICK_CYC = (CLK_HZ + CARRIER_MAX_HZ - 1) / CARRIER_MAX_HZ;

    // Register bus: byte address is four times the register index.
    localparam int          ADDR_W       = 12;
    localparam logic [9:0]  GPIO_CFG_IDX = 10'h05e;
    localparam logic [9:0]  MON_CTRL_IDX = 10'h062;
    localparam logic [9:0]  MON_STAT_IDX = 10'h070;
    localparam int          GPIO_SEL_BIT = 0;
    localparam logic [15:0] MON_CTRL_RST = 16'h4000;
    localparam logic [15:0] MON_CTRL_WMASK = 16'hff3f;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Monitor modes as held in the two top bits of the control register.
    typedef enum logic [1:0] {
        MODE_UNDEF = 2'h0,
        MODE_OFF   = 2'h1,
        MODE_FIRST = 2'h2,
        MODE_THIRD = 2'h3
    } mso_mode_t;

    // Field layout of the monitor output control register.
    typedef struct packed {
        mso_mode_t  mode;
        logic       dacMixMute;
        logic [4:0] dacMixLevel;
        logic [1:0] rsvd;
        logic       adcMixMute;
        logic [4:0] adcMixLevel;
    } mso_ctrl_t;

    // One pair of codec samples, two's complement.
    typedef struct packed {
        logic [15:0] adc;
        logic [15:0] dac;
    } mso_sample_t;

    // Mix level: 3 dB a step, clamped to the permitted span.
    localparam logic signed [5:0] LVL_MIN    = 6'sh3a;
    localparam logic signed [5:0] LVL_MAX    = 6'sh0f;
    localparam logic [15:0]       MANT_UNITY = 16'h4000;
    localparam logic [15:0]       MANT_ROOT2 = 16'h5a82;
    localparam int                MANT_FRAC  = 14;

    // Third-order loop: integrator width and full-scale feedback.
    localparam int                 ACC3_W  = 24;
    localparam logic signed [23:0] FB_FULL = 24'sh010000;
endpackage

// *** design/mso_pair_buf.sv ***
`timescale 1ns/1ps
// **********************************************************************
// Small FIFO with valid and ready on both sides.
// **********************************************************************
module mso_pair_buf #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    input  wire logic             mclk,     // System clock.
    input  wire logic             rst_n,    // Asynchronous reset.
    input  wire logic [WIDTH-1:0] inData,   // Word offered.
    input  wire logic             inValid,  // Word offered is valid.
    output logic                  inReady,  // Room for a word.
    output logic [WIDTH-1:0]      outData,  // Oldest word.
    output logic                  outValid, // Oldest word is valid.
    input  wire logic             outReady  // Drain takes the word.
);
    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [IW-1:0]    wrIdx_reg;
    logic [IW-1:0]    rdIdx_reg;
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    logic             push;
    logic             pop;

    // Handshakes on both sides; ready is a flop, so push never overflows.
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outValid = (count_reg != '0);
    assign outData  = mem[rdIdx_reg];

    // Occupancy after this cycle.
    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + CW'(1);
        end else if (pop && !push) begin
            count_next = count_reg - CW'(1);
        end
    end

    // Storage written at the write index.
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wrIdx_reg] <= inData;
        end
    end

    // Pointers, count and the registered ready.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrIdx_reg <= '0;
            rdIdx_reg <= '0;
            count_reg <= '0;
            inReady   <= 1'b1;
        end else begin
            if (push) begin
                wrIdx_reg <= (wrIdx_reg == IW'(DEPTH - 1)) ? '0
                                                          : wrIdx_reg + IW'(1);
            end
            if (pop) begin
                rdIdx_reg <= (rdIdx_reg == IW'(DEPTH - 1)) ? '0
                                                          : rdIdx_reg + IW'(1);
            end
            count_reg <= count_next;
            inReady   <= (count_next < CW'(DEPTH));
        end
    end
endmodule

// *** design/mso_gain.sv ***
`timescale 1ns/1ps
// **********************************************************************
// Mix gain stage: two's complement level in 3 dB steps, with mute.
// **********************************************************************
module mso_gain #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] sampleIn,  // Sample, two's complement.
    input  wire logic [4:0]   level,     // Gain, 3 dB a step.
    input  wire logic         mute,      // High forces zero.
    output logic [W-1:0]      sampleOut  // Scaled sample, saturated.
);
    localparam int PW = W + 34;

    logic signed [5:0]    lvl;
    logic signed [5:0]    sh;
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] scaled;
    logic signed [PW-1:0] maxV;
    logic signed [PW-1:0] minV;

    // Odd steps use a square-root-of-two mantissa, even steps a shift.
    always_comb begin
        lvl = $signed({level[4], level});
        if (lvl < mso_pkg::LVL_MIN) begin
            lvl = mso_pkg::LVL_MIN;
        end else if (lvl > mso_pkg::LVL_MAX) begin
            lvl = mso_pkg::LVL_MAX;
        end
        sh   = lvl >>> 1;
        prod = PW'($signed(sampleIn)) * PW'($signed({1'b0,
               (lvl[0] ? mso_pkg::MANT_ROOT2 : mso_pkg::MANT_UNITY)}));
        if (sh >= 0) begin
            scaled = prod <<< sh;
        end else begin
            scaled = prod >>> (-sh);
        end
        scaled = scaled >>> mso_pkg::MANT_FRAC;
        maxV   = PW'(2 ** (W - 1) - 1);
        minV   = -PW'(2 ** (W - 1));
        if (mute) begin
            sampleOut = '0;
        end else if (scaled > maxV) begin
            sampleOut = maxV[W-1:0];
        end else if (scaled < minV) begin
            sampleOut = minV[W-1:0];
        end else begin
            sampleOut = scaled[W-1:0];
        end
    end
endmodule

// *** design/mso_monitor_out.sv ***
`timescale 1ns/1ps
// **********************************************************************
// Notes on behaviour
// RULE_01: Control register takes 0x4000 only at power-on, never at other resets.
// RULE_02: Pin carries the monitor stream only while monitor pin select is 1.
// RULE_03: Monitor value is the gained ADC sample plus the gained DAC sample.
// RULE_04: Enabled output is a one-bit stream, bit rate at most 512 kHz.
// RULE_05: Mode 01, the default, stops the modulator and holds output low.
// RULE_06: Mode 10 runs a first-order modulator, ones density 0% to 100%.
// RULE_07: Mode 11 runs a third-order modulator, ones density 0% to 75%.
// RULE_08: First order has 2.5 dB more swing; third order three-quarter swing.
// RULE_09: DAC mix mute set makes the DAC share zero; else level applies.
// RULE_10: Five-bit level is two's complement, 3 dB steps, +45 dB to -18 dB.
// RULE_11: ADC mix mute and level act on the ADC share the same way.
// RULE_12: Undefined mode 00 behaves as powered down, output low.
// **********************************************************************
module mso_monitor_out #(
    parameter int TICK_CYC = mso_pkg::TICK_CYC
) (
    input  wire logic                      mclk,         // 40 MHz clock.
    input  wire logic                      rst_n,        // System reset.
    input  wire logic                      powerOnRst_n, // Power-on reset.
    input  wire logic [mso_pkg::ADDR_W-1:0] awaddr,      // AXI write addr.
    input  wire logic                      awvalid,      // AXI.
    output logic                           awready,      // AXI.
    input  wire logic [31:0]               wdata,        // AXI write data.
    input  wire logic [3:0]                wstrb,        // AXI byte lanes.
    input  wire logic                      wvalid,       // AXI.
    output logic                           wready,       // AXI.
    output logic [1:0]                     bresp,        // AXI.
    output logic                           bvalid,       // AXI.
    input  wire logic                      bready,       // AXI.
    input  wire logic [mso_pkg::ADDR_W-1:0] araddr,      // AXI read addr.
    input  wire logic                      arvalid,      // AXI.
    output logic                           arready,      // AXI.
    output logic [31:0]                    rdata,        // AXI read data.
    output logic [1:0]                     rresp,        // AXI.
    output logic                           rvalid,       // AXI.
    input  wire logic                      rready,       // AXI.
    input  wire mso_pkg::mso_sample_t      sampleIn,     // Codec pair.
    input  wire logic                      sampleValid,  // Pair valid.
    output logic                           sampleReady,  // Pair taken.
    input  wire logic                      gpioOut,      // GPIO level.
    input  wire logic                      gpioOe_n,     // GPIO enable.
    output logic                           pinOut,       // Shared pin out.
    output logic                           pinOe_n       // Low drives pin.
);
    // ******************************************************************
    // Register bus
    // ******************************************************************
    mso_pkg::mso_ctrl_t          ctrl_reg;
    logic                        pinSel_reg;
    logic [mso_pkg::ADDR_W-1:0]  awAddr_reg;
    logic [31:0]                 wData_reg;
    logic [3:0]                  wStrb_reg;
    logic [9:0]                  wIdx;
    logic [9:0]                  rIdx;
    logic                        doWrite;
    logic                        monOn;
    logic                        third;
    logic [15:0]                 mix_reg;
    logic                        monBit_reg;

    assign wIdx    = awAddr_reg[mso_pkg::ADDR_W-1:2];
    assign rIdx    = araddr[mso_pkg::ADDR_W-1:2];
    assign doWrite = !awready && !wready && !bvalid;

    // Address and data are taken in either order, held until the answer.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awready    <= 1'b1;
            wready     <= 1'b1;
            bvalid     <= 1'b0;
            bresp      <= mso_pkg::RESP_OKAY;
            awAddr_reg <= '0;
            wData_reg  <= '0;
            wStrb_reg  <= '0;
        end else begin
            if (awvalid && awready) begin
                awready    <= 1'b0;
                awAddr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                wready    <= 1'b0;
                wData_reg <= wdata;
                wStrb_reg <= wstrb;
            end
            if (doWrite) begin
                bvalid <= 1'b1;
                bresp  <= (wIdx == mso_pkg::MON_CTRL_IDX ||
                           wIdx == mso_pkg::GPIO_CFG_IDX ||
                           wIdx == mso_pkg::MON_STAT_IDX)
                          ? mso_pkg::RESP_OKAY : mso_pkg::RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Monitor control: set to 0x4000 by power-on only, system reset leaves it.
    always_ff @(posedge mclk or negedge powerOnRst_n) begin
        if (!powerOnRst_n) begin
            ctrl_reg <= mso_pkg::MON_CTRL_RST; // RULE_01
        end else if (doWrite && wIdx == mso_pkg::MON_CTRL_IDX) begin
            if (wStrb_reg[0]) begin
                ctrl_reg[7:0] <= wData_reg[7:0] & mso_pkg::MON_CTRL_WMASK[7:0];
            end
            if (wStrb_reg[1]) begin
                ctrl_reg[15:8] <= wData_reg[15:8];
            end
        end
    end

    // Pin select in the GPIO configuration register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinSel_reg <= 1'b0;
        end else if (doWrite && wIdx == mso_pkg::GPIO_CFG_IDX &&
                     wStrb_reg[0]) begin
            pinSel_reg <= wData_reg[mso_pkg::GPIO_SEL_BIT];
        end
    end

    // Reads answer one cycle after the address is taken.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= mso_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= mso_pkg::RESP_OKAY;
            unique case (rIdx)
                mso_pkg::MON_CTRL_IDX: rdata <= {16'h0000, ctrl_reg};
                mso_pkg::GPIO_CFG_IDX: rdata <= {31'h0, pinSel_reg};
                mso_pkg::MON_STAT_IDX: begin
                    rdata <= {13'h0, monBit_reg, third, monOn, mix_reg};
                end
                default: begin
                    rdata <= '0;
                    rresp <= mso_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ******************************************************************
    // Sample path and mix
    // ******************************************************************
    mso_pkg::mso_sample_t headPair;
    logic                 headValid;
    logic                 tick;
    logic [15:0]          adcPart;
    logic [15:0]          dacPart;
    logic signed [16:0]   mixSum;

    // Two-entry buffer; the modulator drains one pair per bit period.
    mso_pair_buf #(.WIDTH($bits(mso_pkg::mso_sample_t)), .DEPTH(2)) u_buf (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .inData   (sampleIn),
        .inValid  (sampleValid),
        .inReady  (sampleReady),
        .outData  (headPair),
        .outValid (headValid),
        .outReady (tick)
    );

    // ADC share scaled and muted like the DAC share.
    mso_gain #(.W(16)) u_adcGain (
        .sampleIn  (headPair.adc),
        .level     (ctrl_reg.adcMixLevel),
        .mute      (ctrl_reg.adcMixMute),
        .sampleOut (adcPart)
    ); // RULE_11

    // DAC share, zero when muted, else scaled by its level.
    mso_gain #(.W(16)) u_dacGain (
        .sampleIn  (headPair.dac),
        .level     (ctrl_reg.dacMixLevel),
        .mute      (ctrl_reg.dacMixMute),
        .sampleOut (dacPart)
    ); // RULE_09 RULE_10

    assign mixSum = $signed({adcPart[15], adcPart}) +
                    $signed({dacPart[15], dacPart}); // RULE_03

    // Saturated mix is latched once per bit period.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mix_reg <= '0;
        end else if (tick && headValid) begin
            if (mixSum > 17'sh07fff) begin
                mix_reg <= 16'h7fff;
            end else if (mixSum < -17'sh08000) begin
                mix_reg <= 16'h8000;
            end else begin
                mix_reg <= mixSum[15:0];
            end
        end
    end

    // ******************************************************************
    // Modulator
    // ******************************************************************
    logic [6:0]                         tickCnt_reg;
    logic [15:0]                        acc1_reg;
    logic [16:0]                        acc1Sum;
    logic [15:0]                        uLevel;
    logic signed [mso_pkg::ACC3_W-1:0]  i1_reg, i2_reg, i3_reg;
    logic signed [mso_pkg::ACC3_W-1:0]  i1n, i2n, i3n, fb, u3;

    assign monOn = (ctrl_reg.mode == mso_pkg::MODE_FIRST) ||
                   (ctrl_reg.mode == mso_pkg::MODE_THIRD); // RULE_05 RULE_12
    assign third = (ctrl_reg.mode == mso_pkg::MODE_THIRD);
    assign tick  = (tickCnt_reg == 7'(TICK_CYC - 1));

    // Bit-rate divider; one bit per TICK_CYC cycles caps the carrier.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt_reg <= '0;
        end else begin
            tickCnt_reg <= tick ? '0 : tickCnt_reg + 7'h01; // RULE_04
        end
    end

    // Offset binary level; third order gets three quarters of the span.
    always_comb begin
        uLevel  = {~mix_reg[15], mix_reg[14:0]};
        acc1Sum = {1'b0, acc1_reg} + {1'b0, uLevel}; // RULE_06
        u3  = (mso_pkg::ACC3_W'({uLevel, 1'b0}) +
               mso_pkg::ACC3_W'(uLevel)) >>> 2;
        fb  = monBit_reg ? mso_pkg::FB_FULL : '0;
        i1n = i1_reg + u3 - fb; // RULE_07 RULE_08
        i2n = i2_reg + (i1n >>> 1) - fb;
        i3n = i3_reg + (i2n >>> 2) - fb;
    end

    // Loop state advances on the bit tick and is cleared while off.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc1_reg   <= '0;
            i1_reg     <= '0;
            i2_reg     <= '0;
            i3_reg     <= '0;
            monBit_reg <= 1'b0;
        end else if (!monOn) begin
            acc1_reg   <= '0;
            i1_reg     <= '0;
            i2_reg     <= '0;
            i3_reg     <= '0;
            monBit_reg <= 1'b0; // RULE_05 RULE_12
        end else if (tick) begin
            if (third) begin
                i1_reg     <= i1n;
                i2_reg     <= i2n;
                i3_reg     <= i3n;
                monBit_reg <= (i3n >= 0); // RULE_07
            end else begin
                acc1_reg   <= acc1Sum[15:0];
                monBit_reg <= acc1Sum[16]; // RULE_06
            end
        end
    end

    // Shared pin: monitor stream when selected, GPIO otherwise.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinOut  <= 1'b0;
            pinOe_n <= 1'b1;
        end else begin
            pinOut  <= pinSel_reg ? monBit_reg : gpioOut; // RULE_02
            pinOe_n <= pinSel_reg ? 1'b0 : gpioOe_n;
        end
    end

    // ******************************************************************
    // Checks
    // ******************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_off_held_low: assert property ( // RULE_05
        !monOn ##1 !monOn |-> !monBit_reg)
        else $error("Monitor bit high while powered down.");
    a_bit_on_tick: assert property ( // RULE_04
        $changed(monBit_reg) |-> $past(tick) || $past(!monOn))
        else $error("Monitor bit changed between bit ticks.");
    a_tick_spacing: assert property ( // RULE_04
        tick |=> !tick [*8])
        else $error("Bit ticks too close together.");
    a_pin_monitor: assert property ( // RULE_02
        pinSel_reg |=> !pinOe_n && pinOut == $past(monBit_reg))
        else $error("Pin does not carry the monitor stream.");
    a_pin_gpio: assert property ( // RULE_02
        !pinSel_reg |=> pinOut == $past(gpioOut) &&
        pinOe_n == $past(gpioOe_n))
        else $error("Pin does not follow the GPIO.");
    a_ctrl_kept: assert property ( // RULE_01
        @(posedge mclk) disable iff (!powerOnRst_n)
        !rst_n && !$past(doWrite) |-> $stable(ctrl_reg))
        else $error("Control register changed by system reset.");
    a_dac_muted: assert property ( // RULE_09
        ctrl_reg.dacMixMute |-> dacPart == 16'h0000)
        else $error("Muted DAC share is not zero.");
    a_adc_muted: assert property ( // RULE_11
        ctrl_reg.adcMixMute |-> adcPart == 16'h0000)
        else $error("Muted ADC share is not zero.");
    a_mix_latch: assert property ( // RULE_03
        tick && headValid && !mixSum[16] && !mixSum[15]
        |=> mix_reg == $past(mixSum[15:0]))
        else $error("Mix does not equal the sum of its shares.");
    a_first_full: assert property ( // RULE_06
        monOn && !third && mix_reg == 16'h7fff && tick ##1
        monOn && !third && mix_reg == 16'h7fff
        |-> monBit_reg || $past(acc1_reg) == 16'h0000)
        else $error("First order loses full-scale ones density.");

    c_first_order: cover property (
        ctrl_reg.mode == mso_pkg::MODE_FIRST && $rose(monBit_reg));
    c_third_order: cover property (third && $rose(monBit_reg));
    c_buf_full: cover property (sampleValid && !sampleReady);
    c_pin_select: cover property ($rose(pinSel_reg));
endmodule

// *** verification/mso_rc_filter.sv ***
`timescale 1ns/1ps
// **********************************************************************
// Board filter: counts ones and the shortest level run on the pin.
// **********************************************************************
module mso_rc_filter (
    input  wire logic mclk,    // System clock.
    input  wire logic clr,     // Starts a new count window.
    input  wire logic pinOut,  // Level driven by the block.
    input  wire logic pinOe_n, // Low while the block drives.
    output int        highCnt, // Cycles seen high.
    output int        minRun   // Shortest complete run, in cycles.
);
    int   run;
    logic last;
    logic pad;

    // The resistor to ground pulls an undriven pin low.
    assign pad = pinOe_n ? 1'b0 : pinOut;

    // The first partial run is ignored by starting the count high.
    always @(posedge mclk) begin
        if (clr) begin
            highCnt <= 0;
            run     <= 1 << 20;
            minRun  <= 1 << 20;
        end else begin
            highCnt <= highCnt + int'(pad);
            if (pad !== last) begin
                if (run < minRun) minRun <= run;
                run <= 1;
            end else begin
                run <= run + 1;
            end
        end
        last <= pad;
    end
endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ps
// **********************************************************************
// Register, pin and stream tests of the monitor output.
// **********************************************************************
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tb;
    localparam int          TICK = 10;
    localparam logic [11:0] CTRL = 12'h188;
    localparam logic [11:0] GPIO = 12'h178;
    logic mclk = 0, rst_n = 0, powerOnRst_n = 0, clr = 1;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic sampleValid = 1, gpioOut = 1, gpioOe_n = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, resp;
    logic awready, wready, bvalid, arready, rvalid, sampleReady;
    logic pinOut, pinOe_n;
    mso_pkg::mso_sample_t sampleIn = '0;
    int failures = 0, checksDone = 0, highCnt, minRun, h0, h1;

    mso_monitor_out #(.TICK_CYC(TICK)) uut (.mclk, .rst_n, .powerOnRst_n,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .sampleIn, .sampleValid, .sampleReady,
        .gpioOut, .gpioOe_n, .pinOut, .pinOe_n);
    mso_rc_filter filt (.mclk, .clr, .pinOut, .pinOe_n, .highCnt, .minRun);

    // Free-running 40 MHz clock.
    initial forever #12.5 mclk = ~mclk;

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test(input bit hung);
        if (hung) failures++;
        $display("checks %0d failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // AXI write; each channel is released at the edge that takes it.
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        int n;
        @(posedge mclk);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge mclk);
            if (awvalid && awready === 1'b1) awvalid <= 0;
            if (wvalid && wready === 1'b1) wvalid <= 0;
            if (bvalid === 1'b1) break;
        end
        resp = bresp; bready <= 0;
        if (n == 100) end_of_test(1);
    endtask

    // AXI read; data and response are taken at the rvalid edge.
    task automatic rd(input logic [11:0] a);
        int n;
        @(posedge mclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge mclk);
            if (arvalid && arready === 1'b1) arvalid <= 0;
            if (rvalid === 1'b1) break;
        end
        d = rdata; resp = rresp; rready <= 0;
        if (n == 100) end_of_test(1);
    endtask

    // Settles, then counts ones over 200 bit periods.
    task automatic meas(input logic [31:0] c, output int h);
        wr(CTRL, c);
        repeat (300) @(posedge mclk);
        clr <= 1;
        @(posedge mclk);
        clr <= 0;
        repeat (2000) @(posedge mclk);
        h = highCnt;
        `CHK(minRun >= TICK, 1'b1)
    endtask

    // Main sequence.
    initial begin
        repeat (8) @(posedge mclk);
        `CHK({pinOe_n, sampleReady}, 2'b11)
        rst_n <= 1; powerOnRst_n <= 1;
        rd(CTRL); `CHK(d, 32'h4000)
        `CHK({pinOut, pinOe_n}, {gpioOut, gpioOe_n})
        gpioOut <= 0;
        wr(CTRL, 32'hffff);
        `CHK(resp, 2'h0)
        rd(CTRL); `CHK(d, 32'hff3f)
        `CHK({pinOut, pinOe_n}, 2'b00)
        rst_n <= 0; repeat (8) @(posedge mclk); rst_n <= 1;
        rd(CTRL); `CHK(d, 32'hff3f)
        rd(12'h3fc); `CHK({resp, d}, {2'h2, 32'h0})
        wr(12'h3fc, 32'h1); `CHK(resp, 2'h2)
        $display("test registers done");
        wr(GPIO, 32'h1); sampleIn <= {16'h7fff, 16'h8000};
        meas(32'h4000, h0); `CHK(h0, 0)
        `CHK(pinOe_n, 1'b0)
        meas(32'h2000, h0); `CHK(h0, 0)
        meas(32'ha000, h0); `CHK(h0 > 1200, 1'b1)
        meas(32'he000, h1); `CHK(h1 <= 1600, 1'b1)
        `CHK(h1 < h0, 1'b1)
        sampleIn <= {16'h8000, 16'h7fff};
        meas(32'ha000, h1); `CHK(h1 < 800, 1'b1)
        meas(32'h8020, h0); `CHK(h0 > 1200, 1'b1)
        meas(32'ha020, h1); `CHK(h1 > 800 && h1 < 1200, 1'b1)
        meas(32'h9a20, h1); `CHK(h1 < h0, 1'b1)
        $display("test modulator done");
        end_of_test(0);
    end
endmodule
